// ==== verilog/atc_params.svh ====
// Constants for the acquisition and trigger control block
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH
`define ATC_CLK_HZ    100000000
`define ATC_CLK_NS    10
`define ATC_US_NS     1000
`define ATC_US_CYC    (`ATC_US_NS / `ATC_CLK_NS)
`define ATC_A_CTRL    8'h00
`define ATC_A_CMD     8'h04
`define ATC_A_MCNT    8'h08
`define ATC_A_BCNT    8'h0C
`define ATC_A_RATE    8'h10
`define ATC_A_EXPO    8'h14
`define ATC_A_DLY     8'h18
`define ATC_A_STAT    8'h1C
`define ATC_A_FPS     8'h20
`define ATC_A_AEXP    8'h24
`define ATC_CMD_BEGIN 0
`define ATC_CMD_END   1
`define ATC_CMD_SW    2
`define ATC_MODE_CONT 2'h0
`define ATC_MODE_MULT 2'h1
`define ATC_MODE_SNGL 2'h2
`define ATC_AE_OFF    2'h0
`define ATC_AE_ONCE   2'h1
`define ATC_AE_CONT   2'h2
`define ATC_TT_ACQ    2'h0
`define ATC_TT_IMG    2'h1
`define ATC_TT_BURST  2'h2
`define ATC_TT_BEND   3
`define ATC_ACT_LOW   3'h0
`define ATC_ACT_HIGH  3'h1
`define ATC_ACT_FALL  3'h2
`define ATC_ACT_RISE  3'h3
`define ATC_ACT_ANY   3'h4
`define ATC_SRC_SW    4'h0
`define ATC_SRC_N     4'hE
`define ATC_CTRL_RST  32'h00000020
`define ATC_MCNT_RST  16'h0001
`define ATC_BCNT_RST  16'h0001
`define ATC_RATE_RST  16'h001E
`define ATC_EXPO_RST  24'h002710
`define ATC_AE_LO     8'h70
`define ATC_AE_HI     8'h90
`define ATC_AE_STEP   24'h000064
`define ATC_AE_MAX    24'hFFFF00
`define ATC_AE_ONCE_N 4'h7
`endif

// ==== verilog/atc_pkg.sv ====
// Types for the acquisition and trigger control block
package atc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_EXPOSE} atc_st_t;
    typedef struct packed {
        logic [11:0] pad;
        logic [3:0]  src;
        logic [2:0]  act;
        logic        ovl;
        logic [3:0]  ten;
        logic [1:0]  tsel;
        logic [1:0]  ae;
        logic        kind;
        logic        rate_on;
        logic [1:0]  mode;
    } atc_ctrl_t;
    typedef struct packed {
        logic       logic_blk;
        logic [1:0] cnt_end;
        logic [1:0] cnt_start;
        logic [3:0] user;
    } atc_src_t;
    typedef struct packed {
        atc_ctrl_t   ctrl;
        logic [15:0] mcnt;
        logic [15:0] bcnt;
        logic [15:0] rate;
        logic [23:0] expo;
        logic [23:0] dly;
        logic [23:0] expv;
        logic [3:0]  sy1;
        logic [3:0]  sy2;
        logic        prev;
        logic        ack;
        logic [31:0] rdat;
        atc_st_t     st;
        logic        armed;
        logic        run;
        logic        inf;
        logic [15:0] left;
        logic [15:0] nfr;
        logic [7:0]  usdiv;
        logic [23:0] tmr;
        logic [31:0] acc;
        logic [31:0] sec;
        logic        pend;
        logic [3:0]  aecnt;
        logic [15:0] fcnt;
        logic [15:0] fps;
        logic        shut;
        logic        ro;
    } atc_state_t;
endpackage

// ==== verilog/atc_top.sv ====
// Acquisition sequencing, exposure and trigger control with Wishbone regs
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "atc_params.svh"
module atc_top #(
    parameter int unsigned SEC_CYCLES = `ATC_CLK_HZ
) (
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic [7:0]     wb_adr_i,
    input  wire logic [31:0]    wb_dat_i,
    input  wire logic [3:0]     wb_sel_i,
    input  wire logic           wb_we_i,
    input  wire logic           wb_cyc_i,
    input  wire logic           wb_stb_i,
    output logic [31:0]         wb_dat_o,
    output logic                wb_ack_o,
    input  wire logic [3:0]     trig_line_i,
    input  wire atc_pkg::atc_src_t int_src_i,
    input  wire logic           readout_busy_i,
    input  wire logic [7:0]     scene_level_i,
    output logic                shutter_open_o,
    output logic                readout_start_o,
    output logic                acquiring_o
);
    localparam logic [7:0]  US_LAST  = 8'(`ATC_US_CYC - 1);
    localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);
    localparam logic [31:0] SEC_LEN  = 32'(SEC_CYCLES);

    atc_pkg::atc_state_t q;
    atc_pkg::atc_state_t d;

    logic        req;
    logic        wr;
    logic        wr_ctrl;
    logic        wr_cmd;
    logic        cmd_begin;
    logic        cmd_end;
    logic        swt;
    logic        us;
    logic        trig_on;
    logic        sel_sig;
    logic        hit;
    logic        lvl;
    logic        accept;
    logic        width;
    logic        fend;
    logic        rate_ok;
    logic        cont;
    logic [13:0] srcv;
    logic [15:0] mode_n;
    logic [23:0] exp_use;

    function automatic logic [31:0] wmerge(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Single-cycle answer; ack drops the cycle after it is given
    assign req       = wb_cyc_i & wb_stb_i & ~q.ack;
    assign wr        = req & wb_we_i;
    assign wr_ctrl   = wr & (wb_adr_i == `ATC_A_CTRL);
    assign wr_cmd    = wr & (wb_adr_i == `ATC_A_CMD) & wb_sel_i[0];
    assign cmd_begin = wr_cmd & wb_dat_i[`ATC_CMD_BEGIN];
    assign cmd_end   = wr_cmd & wb_dat_i[`ATC_CMD_END];
    assign swt       = wr_cmd & wb_dat_i[`ATC_CMD_SW]
                     & (q.ctrl.src == `ATC_SRC_SW);
    assign srcv      = {int_src_i, q.sy2, swt};
    assign sel_sig   = (q.ctrl.src < `ATC_SRC_N) ? srcv[q.ctrl.src] : 1'b0;
    assign trig_on   = (q.ctrl.tsel != 2'h3) & q.ctrl.ten[q.ctrl.tsel];
    assign us        = (q.usdiv == US_LAST);
    assign cont      = (q.ctrl.mode == `ATC_MODE_CONT);
    assign mode_n    = (q.ctrl.mode == `ATC_MODE_SNGL) ? 16'h0001 : q.mcnt;
    assign width     = q.ctrl.kind & trig_on;
    assign exp_use   = (q.ctrl.ae == `ATC_AE_OFF) ? q.expo : q.expv;
    assign rate_ok   = ~q.ctrl.rate_on | q.pend;

    // Active level of the shutter pulse follows the qualifier polarity
    assign lvl = ((q.ctrl.act == `ATC_ACT_LOW) | (q.ctrl.act == `ATC_ACT_FALL))
               ? ~sel_sig : sel_sig;
    assign hit = (q.ctrl.act == `ATC_ACT_LOW)  ? ~sel_sig :
                 (q.ctrl.act == `ATC_ACT_HIGH) ? sel_sig :
                 (q.ctrl.act == `ATC_ACT_FALL) ? (q.prev & ~sel_sig) :
                 (q.ctrl.act == `ATC_ACT_RISE) ? (~q.prev & sel_sig) :
                 (q.ctrl.act == `ATC_ACT_ANY)  ? (q.prev ^ sel_sig) :
                 1'b0;

    // Triggers are refused mid-run, so a burst is never cut short
    assign accept = trig_on & hit & q.armed & ~q.run
                  & (q.st == atc_pkg::ST_IDLE)
                  & ~(readout_busy_i & ~q.ctrl.ovl);

    assign fend = (q.st == atc_pkg::ST_EXPOSE)
                & (width ? ~lvl : (q.tmr >= exp_use));

    always_comb begin
        d      = q;
        d.ack  = 1'b0;
        d.ro   = 1'b0;
        d.sy1  = trig_line_i;
        d.sy2  = q.sy1;
        d.prev = sel_sig;
        d.usdiv = us ? 8'h00 : q.usdiv + 8'h01;

        // Frames finished per second window
        if (q.sec == SEC_LAST) begin
            d.sec  = 32'h00000000;
            d.fps  = q.fcnt + {15'h0000, fend};
            d.fcnt = 16'h0000;
        end else begin
            d.sec = q.sec + 32'h00000001;
            if (fend) begin
                d.fcnt = q.fcnt + 16'h0001;
            end
        end

        case (q.st)
            atc_pkg::ST_IDLE: begin
                if (accept) begin
                    d.run   = 1'b1;
                    d.nfr   = 16'h0000;
                    d.st    = atc_pkg::ST_DELAY;
                    d.tmr   = 24'h000000;
                    d.usdiv = 8'h00;
                    case (q.ctrl.tsel)
                        `ATC_TT_ACQ: begin
                            d.left  = mode_n;
                            d.inf   = cont;
                            d.armed = 1'b0;
                        end
                        `ATC_TT_IMG: begin
                            d.left  = cont ? 16'h0001 : mode_n;
                            d.inf   = 1'b0;
                            d.armed = cont;
                        end
                        default: begin
                            d.left  = cont ? q.bcnt : mode_n;
                            d.inf   = cont & q.ctrl.ten[`ATC_TT_BEND];
                            d.armed = 1'b1;
                        end
                    endcase
                end else if (q.run & (q.inf | (q.left != 16'h0000))
                             & rate_ok) begin
                    d.st    = atc_pkg::ST_EXPOSE;
                    d.tmr   = 24'h000000;
                    d.usdiv = 8'h00;
                    d.pend  = 1'b0;
                end else if (q.run & ~q.inf & (q.left == 16'h0000)) begin
                    d.run = 1'b0;
                end
            end
            atc_pkg::ST_DELAY: begin
                if (q.tmr >= q.dly) begin
                    d.st    = atc_pkg::ST_EXPOSE;
                    d.tmr   = 24'h000000;
                    d.usdiv = 8'h00;
                end else if (us) begin
                    d.tmr = q.tmr + 24'h000001;
                end
            end
            atc_pkg::ST_EXPOSE: begin
                if (fend) begin
                    d.st  = atc_pkg::ST_IDLE;
                    d.ro  = 1'b1;
                    d.nfr = q.nfr + 16'h0001;
                    if (~q.inf) begin
                        d.left = q.left - 16'h0001;
                        if (q.left == 16'h0001) begin
                            d.run = 1'b0;
                        end
                    end
                    if (q.ctrl.ae != `ATC_AE_OFF) begin
                        if ((scene_level_i < `ATC_AE_LO)
                            & (q.expv < `ATC_AE_MAX)) begin
                            d.expv = q.expv + `ATC_AE_STEP;
                        end else if ((scene_level_i > `ATC_AE_HI)
                                     & (q.expv > `ATC_AE_STEP)) begin
                            d.expv = q.expv - `ATC_AE_STEP;
                        end
                    end
                    if (q.ctrl.ae == `ATC_AE_ONCE) begin
                        if (q.aecnt == `ATC_AE_ONCE_N) begin
                            d.ctrl.ae = `ATC_AE_OFF;
                            d.expo    = d.expv;
                            d.aecnt   = 4'h0;
                        end else begin
                            d.aecnt = q.aecnt + 4'h1;
                        end
                    end
                end else if (us) begin
                    d.tmr = q.tmr + 24'h000001;
                end
            end
            default: begin
                d.st = atc_pkg::ST_IDLE;
            end
        endcase

        // Pacing tick sets after a frame start clears, so none is lost
        if (q.ctrl.rate_on) begin
            if (q.acc + {16'h0000, q.rate} >= SEC_LEN) begin
                d.acc  = q.acc + {16'h0000, q.rate} - SEC_LEN;
                d.pend = 1'b1;
            end else begin
                d.acc = q.acc + {16'h0000, q.rate};
            end
        end else begin
            d.acc  = 32'h00000000;
            d.pend = 1'b0;
        end

        // Register bus; software writes land after hardware updates
        if (req) begin
            d.ack = 1'b1;
            case (wb_adr_i)
                `ATC_A_CTRL: d.rdat = q.ctrl;
                `ATC_A_MCNT: d.rdat = {16'h0000, q.mcnt};
                `ATC_A_BCNT: d.rdat = {16'h0000, q.bcnt};
                `ATC_A_RATE: d.rdat = {16'h0000, q.rate};
                `ATC_A_EXPO: d.rdat = {8'h00, q.expo};
                `ATC_A_DLY:  d.rdat = {8'h00, q.dly};
                `ATC_A_STAT: d.rdat = {q.nfr, 12'h000, q.armed, q.run,
                                       q.st == atc_pkg::ST_DELAY, q.shut};
                `ATC_A_FPS:  d.rdat = {16'h0000, q.fps};
                `ATC_A_AEXP: d.rdat = {8'h00, q.expv};
                default:     d.rdat = 32'h00000000;
            endcase
        end
        if (wr) begin
            case (wb_adr_i)
                `ATC_A_CTRL: begin
                    d.ctrl     = wmerge(q.ctrl, wb_dat_i, wb_sel_i);
                    d.ctrl.pad = 12'h000;
                    d.aecnt    = 4'h0;
                end
                // Narrow registers keep the low bits of the merged word
                `ATC_A_MCNT: d.mcnt = 16'(wmerge({16'h0000, q.mcnt},
                                                 wb_dat_i, wb_sel_i));
                `ATC_A_BCNT: d.bcnt = 16'(wmerge({16'h0000, q.bcnt},
                                                 wb_dat_i, wb_sel_i));
                `ATC_A_RATE: d.rate = 16'(wmerge({16'h0000, q.rate},
                                                 wb_dat_i, wb_sel_i));
                `ATC_A_EXPO: d.expo = 24'(wmerge({8'h00, q.expo},
                                                 wb_dat_i, wb_sel_i));
                `ATC_A_DLY:  d.dly = 24'(wmerge({8'h00, q.dly},
                                                wb_dat_i, wb_sel_i));
                default: begin
                end
            endcase
        end
        if (cmd_begin) begin
            d.nfr  = 16'h0000;
            d.tmr  = 24'h000000;
            if (trig_on) begin
                d.armed = 1'b1;
                d.run   = 1'b0;
            end else begin
                d.armed = 1'b0;
                d.run   = 1'b1;
                d.left  = mode_n;
                d.inf   = cont;
            end
        end
        if (cmd_end) begin
            d.run   = 1'b0;
            d.armed = 1'b0;
            d.st    = atc_pkg::ST_IDLE;
            d.tmr   = 24'h000000;
        end
        d.shut = (d.st == atc_pkg::ST_EXPOSE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q      <= '0;
            q.ctrl <= `ATC_CTRL_RST;
            q.mcnt <= `ATC_MCNT_RST;
            q.bcnt <= `ATC_BCNT_RST;
            q.rate <= `ATC_RATE_RST;
            q.expo <= `ATC_EXPO_RST;
            q.expv <= `ATC_EXPO_RST;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o        = q.rdat;
    assign wb_ack_o        = q.ack;
    assign shutter_open_o  = q.shut;
    assign readout_start_o = q.ro;
    assign acquiring_o     = q.run;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    capture_reset_a: assert property (
        $past(rst_i) |-> q.ctrl.mode == `ATC_MODE_CONT
                      && q.ctrl.ae == `ATC_AE_CONT && !q.ctrl.kind)
        else $error("capture settings wrong after reset");
    trig_reset_a: assert property (
        $past(rst_i) |-> q.ctrl.ten == 4'h0 && !q.armed && !q.run)
        else $error("triggering not off after reset");
    count_stop_a: assert property (
        fend && !q.inf && q.left == 16'h0001 && !cmd_begin
        |=> !q.run && q.ro)
        else $error("counted capture did not stop");
    cont_keep_a: assert property (
        q.run && q.inf && !cmd_end && !cmd_begin |=> q.run)
        else $error("continuous capture stopped on its own");
    trig_gate_a: assert property (
        $rose(q.st == atc_pkg::ST_DELAY) |-> $past(trig_on && q.armed))
        else $error("trigger honoured while disabled");
    delay_len_a: assert property (
        $past(q.st) == atc_pkg::ST_DELAY && q.st == atc_pkg::ST_EXPOSE
        |-> $past(q.tmr) >= $past(q.dly))
        else $error("shutter opened before trigger wait ended");
    expose_len_a: assert property (
        q.ro && $past(!width && q.ctrl.ae == `ATC_AE_OFF)
        |-> $past(q.tmr) >= $past(q.expo))
        else $error("timed shutter closed early");
    width_end_a: assert property (
        q.st == atc_pkg::ST_EXPOSE && width && !lvl && !cmd_begin
        |=> !q.shut ##1 !q.ro)
        else $error("pulse width shutter outlived trigger");
    once_off_a: assert property (
        $fell(q.ctrl.ae == `ATC_AE_ONCE) && !$past(wr_ctrl)
        && !$past(wr && (wb_adr_i == `ATC_A_EXPO))
        |-> q.ctrl.ae == `ATC_AE_OFF && q.ro && q.expo == q.expv)
        else $error("one-shot auto shutter ended wrongly");
    overlap_a: assert property (
        readout_busy_i && !q.ctrl.ovl && q.st == atc_pkg::ST_IDLE
        && !q.run |=> q.st != atc_pkg::ST_DELAY)
        else $error("trigger taken during readout");
    pace_a: assert property (
        $past(q.st) == atc_pkg::ST_IDLE && q.st == atc_pkg::ST_EXPOSE
        && $past(q.ctrl.rate_on) |-> $past(q.pend))
        else $error("frame started without pacing tick");
    // A begin always restarts the frame tally from zero
    begin_clear_a: assert property (
        cmd_begin |=> q.nfr == 16'h0000)
        else $error("frame tally not cleared at begin");
endmodule // atc_top

// ==== verification/atc_trig_model.sv ====
// Far-side model: trigger line driver and sensor readout busy
`timescale 1ns/10ps
module atc_trig_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       fire_i,
    input  wire logic       readout_start_i,
    output logic [3:0]      trig_line_o,
    output logic            busy_o
);
    logic [3:0] pulse_q;
    logic [2:0] busy_q;
    // Line 0 carries a wide pulse so the synchroniser cannot miss it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_q <= 4'h0;
            busy_q  <= 3'h0;
        end else begin
        if (fire_i) begin
            pulse_q <= 4'hF;
        end else if (pulse_q != 4'h0) begin
            pulse_q <= pulse_q - 4'h1;
        end
        if (readout_start_i) begin
            busy_q <= 3'h7;
        end else if (busy_q != 3'h0) begin
            busy_q <= busy_q - 3'h1;
        end
        end
    end
    assign trig_line_o = {3'h0, pulse_q != 4'h0};
    assign busy_o      = busy_q != 3'h0;
endmodule // atc_trig_model

// ==== verification/tb_acquisition_trigger_control.sv ====
// Self-checking bench for the acquisition and trigger control block
`timescale 1ns/10ps
`include "atc_params.svh"
module tb_acquisition_trigger_control;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, fire;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i, trig_line;
    logic        wb_ack_o, busy, shut, ro_start, acq;
    int          n_errors, checked, frames, len, last_len;
    atc_pkg::atc_src_t int_src;
    initial clk_i = 1'b0;
    always #5 clk_i = ~clk_i;
    atc_top #(.SEC_CYCLES(1000)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .trig_line_i(trig_line),
        .int_src_i(int_src), .readout_busy_i(busy),
        .scene_level_i(8'h80), .shutter_open_o(shut),
        .readout_start_o(ro_start), .acquiring_o(acq));
    atc_trig_model model_u (
        .clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .readout_start_i(ro_start),
        .trig_line_o(trig_line), .busy_o(busy));
    // Tallies taken mid-cycle, where registered outputs have settled
    always @(negedge clk_i) begin
        if (ro_start === 1'b1) frames++;
        if (shut === 1'b1) len++;
        else if (len != 0) begin
            last_len = len;
            len = 0;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One classic cycle; ack is seen mid-cycle, released at its edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(negedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) chk(32'h0, 32'h1);
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask
    task automatic run_and_count(input int exp_frames, input int span);
        repeat (span) @(negedge clk_i);
        chk(32'(frames), 32'(exp_frames));
    endtask
    task automatic t_reset_values();
        wb(1'b0, `ATC_A_CTRL, 32'h0); chk(rd, `ATC_CTRL_RST);
        wb(1'b0, `ATC_A_MCNT, 32'h0); chk(rd, 32'h1);
        wb(1'b0, `ATC_A_RATE, 32'h0); chk(rd, 32'h1E);
        wb(1'b0, `ATC_A_EXPO, 32'h0); chk(rd, 32'h2710);
        wb(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
        wb(1'b1, `ATC_A_FPS, 32'h55);
        wb(1'b0, `ATC_A_FPS, 32'h0); chk(rd, 32'h0);
    endtask
    task automatic t_single();
        wb(1'b1, `ATC_A_EXPO, 32'h1);
        wb(1'b1, `ATC_A_CTRL, 32'h2);
        frames = 0;
        wb(1'b1, `ATC_A_CMD, 32'h1);
        run_and_count(1, 600);
        chk(32'(acq), 32'h0);
        // Exposure of 1 us is about 100 cycles at 100 MHz
        chk(32'(last_len >= 100 && last_len <= 102), 32'h1);
    endtask
    task automatic t_multi();
        wb(1'b1, `ATC_A_MCNT, 32'h3);
        wb(1'b1, `ATC_A_CTRL, 32'h1);
        frames = 0;
        wb(1'b1, `ATC_A_CMD, 32'h1);
        run_and_count(3, 1500);
        chk(32'(acq), 32'h0);
    endtask
    task automatic t_continuous();
        wb(1'b1, `ATC_A_CTRL, 32'h0);
        frames = 0;
        wb(1'b1, `ATC_A_CMD, 32'h1);
        repeat (1000) @(negedge clk_i);
        chk(32'(frames >= 4), 32'h1);
        chk(32'(acq), 32'h1);
        wb(1'b1, `ATC_A_CMD, 32'h2);
        repeat (5) @(negedge clk_i);
        chk(32'(acq), 32'h0);
    endtask
    task automatic t_paced();
        // Rate 2 gives a tick every 500 cycles; each frame waits for one
        wb(1'b1, `ATC_A_RATE, 32'h2);
        wb(1'b1, `ATC_A_CTRL, 32'h4);
        frames = 0;
        wb(1'b1, `ATC_A_CMD, 32'h1);
        repeat (2700) @(negedge clk_i);
        chk(32'(frames >= 4 && frames <= 6), 32'h1);
        wb(1'b0, `ATC_A_FPS, 32'h0);
        chk(rd, 32'h2);
        wb(1'b1, `ATC_A_CMD, 32'h2);
        wb(1'b1, `ATC_A_CTRL, 32'h0);
    endtask
    task automatic t_soft_trig();
        // Level-high qualifier; origin is line 0 first, so the host
        // trigger must be ignored
        wb(1'b1, `ATC_A_CTRL, 32'h12102);
        frames = 0;
        wb(1'b1, `ATC_A_CMD, 32'h1);
        wb(1'b1, `ATC_A_CMD, 32'h4);
        run_and_count(0, 400);
        wb(1'b1, `ATC_A_CTRL, 32'h02102);
        wb(1'b1, `ATC_A_CMD, 32'h1);
        run_and_count(0, 50);
        wb(1'b1, `ATC_A_CMD, 32'h4);
        run_and_count(1, 600);
        // User output 0 as origin, one-cycle pulse
        wb(1'b1, `ATC_A_CTRL, 32'h52102);
        wb(1'b1, `ATC_A_CMD, 32'h1);
        @(posedge clk_i) int_src <= 9'h001;
        @(posedge clk_i) int_src <= 9'h000;
        run_and_count(2, 600);
    endtask
    task automatic t_line_trig();
        // Per-image type, continuous, rising edge on line 0
        wb(1'b1, `ATC_A_CTRL, 32'h16240);
        wb(1'b1, `ATC_A_DLY, 32'h2);
        frames = 0;
        wb(1'b1, `ATC_A_CMD, 32'h1);
        repeat (2) begin
            @(posedge clk_i) fire <= 1'b1;
            @(posedge clk_i) fire <= 1'b0;
            repeat (100) @(negedge clk_i);
            chk(32'(shut), 32'h0);
            repeat (600) @(posedge clk_i);
        end
        chk(32'(frames), 32'h2);
        wb(1'b1, `ATC_A_CMD, 32'h2);
    endtask
    initial begin
        n_errors = 0; checked = 0; frames = 0; len = 0; last_len = 0;
        rst_i = 1'b1; fire = 1'b0; wb_we_i = 1'b0; wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0; wb_adr_i = 8'h0; wb_dat_i = 32'h0;
        wb_sel_i = 4'hF;
        int_src = '0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset_values();
        t_single();
        t_multi();
        t_continuous();
        t_paced();
        t_soft_trig();
        t_line_trig();
        conclude();
    end
    // Scenarios need about 9000 cycles; the span leaves wide margin
    initial begin
        #(40000 * 10);
        n_errors++;
        conclude();
    end
endmodule // tb_acquisition_trigger_control
